//--- rtl/wdg_supervision_timer.sv
// Notes on behaviour
// - counter steps on the 256 Hz tick, only while slow oscillator runs
// - overflow after 1024 ticks, that is 131072 oscillator periods, uncleared
// - halt does not stop counting; overflow raises nmi or reset
// - sleep gates the tick off, so counting pauses until it returns
// - control at 0x5040, status at 0x5041, both eight bits
// - reserved bits read zero; software writes them as zero
// - writing one to control bit 4 zeroes counter; bit reads zero
// - run code 0b1010 stops counting, other values run; resets stopped
// - status bit 1 selects reset when one, nmi when zero
// - status bit 0 set by overflow, cleared by timer clear
// - flag also set in reset action; system reset then clears it
//
// Added by the designer: the plain strobed port.
module wdg_supervision_timer #(
	parameter int unsigned CNT_W = wdg_pkg::CNT_W
) (
	input wire logic clk, // system clock, 25 MHz
	input wire logic rst, // async reset, active high
	input wire logic clkEn, // freezes all state when low
	input wire logic tickIn, // 256 Hz tick from the clock generator unit
	input wire logic slowOscOn, // slow oscillator running
	input wire logic sleepMode, // clock generator gates the tick off
	input wire logic [wdg_pkg::ADDR_W-1:0] busAddr, // register byte address
	input wire logic [wdg_pkg::DATA_W-1:0] busWdata, // write data
	input wire logic busWr, // write strobe
	input wire logic busRd, // read strobe
	output logic [wdg_pkg::DATA_W-1:0] busRdata, // read data, cycle after strobe
	output logic nmiReq, // nmi request pulse
	output logic resetReq, // system reset request pulse
	output logic irq // level interrupt
);
	import wdg_pkg::*;

	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
	localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	// synchronised pins
	logic tickSync;
	logic oscSync;
	logic sleepSync;
	logic tickLast;

	// tick qualification
	logic tickRise;
	logic tickEv;
	logic running;
	logic step;
	logic ovfEv;

	// bus decode
	logic wrCtl;
	logic wrSt;
	logic wrIrqClr;
	logic wrIrqEn;
	logic clrWr;

	// block state
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [3:0] runCode;
	wdg_action_t mode;
	logic ovfFlag;
	logic nmiPulse;
	logic rstPulse;
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqEnable;
	logic [IRQ_W-1:0] irqEvents;
	logic [DATA_W-1:0] next_rdata;

	// refuse counter widths the logic cannot serve
	generate
		if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
			$error("CNT_W must lie between 2 and 16");
		end
	endgenerate

	// pins from the clock generator cross into the bus clock
	wdg_sync #(
		.WIDTH(3)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.clkEn(clkEn),
		.asyncIn({sleepMode, slowOscOn, tickIn}),
		.syncOut({sleepSync, oscSync, tickSync})
	);

	// remember the tick level for edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tickLast <= 1'b0;
		end else if (clkEn) begin
			tickLast <= tickSync;
		end
	end

	// a tick counts only with the oscillator on and outside sleep
	assign tickRise = tickSync & ~tickLast;
	assign tickEv = tickRise & oscSync & ~sleepSync;

	// any code but the stop code runs; halt has no say here
	assign running = (runCode != RUN_STOP_CODE);
	assign step = running & tickEv;

	// wrap from all ones is the overflow
	assign ovfEv = step & (cnt == CNT_MAX);

	// register decode, only while the clock enable is high
	assign wrCtl = clkEn & busWr & (busAddr == CTL_ADDR);
	assign wrSt = clkEn & busWr & (busAddr == ST_ADDR);
	assign wrIrqClr = clkEn & busWr & (busAddr == IRQ_CLR_ADDR);
	assign wrIrqEn = clkEn & busWr & (busAddr == IRQ_EN_ADDR);

	// writing zero to the clear bit does nothing
	assign clrWr = wrCtl & busWdata[CTL_CLR_BIT];

	// next counter value: clear beats a tick
	always_comb begin
		next_cnt = cnt;
		if (clrWr) begin
			next_cnt = '0;
		end else if (step) begin
			next_cnt = cnt + CNT_ONE;
		end
	end

	// watchdog up-counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
		end else if (clkEn) begin
			cnt <= next_cnt;
		end
	end

	// run/stop code, stopped after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			runCode <= RUN_RESET_VAL;
		end else if (wrCtl) begin
			runCode <= busWdata[CTL_RUN_LSB +: CTL_RUN_W];
		end
	end

	// overflow action select
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode <= wdg_action_t'(MODE_RESET_VAL);
		end else if (wrSt) begin
			mode <= wdg_action_t'(busWdata[ST_MODE_BIT]);
		end
	end

	// overflow flag: overflow wins over a clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovfFlag <= FLAG_RESET_VAL;
		end else if (clkEn) begin
			if (ovfEv) begin
				ovfFlag <= 1'b1;
			end else if (clrWr) begin
				ovfFlag <= 1'b0;
			end
		end
	end

	// one pulse per overflow, routed by the action select
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nmiPulse <= 1'b0;
			rstPulse <= 1'b0;
		end else if (clkEn) begin
			nmiPulse <= ovfEv & (mode == WDG_ACT_NMI);
			rstPulse <= ovfEv & (mode == WDG_ACT_RESET);
		end
	end

	// a frozen clock enable must not stretch a pulse
	assign nmiReq = nmiPulse & clkEn;
	assign resetReq = rstPulse & clkEn;

	// interrupt events mirror the two requests
	assign irqEvents[IRQ_NMI_BIT] = ovfEv & (mode == WDG_ACT_NMI);
	assign irqEvents[IRQ_RST_BIT] = ovfEv & (mode == WDG_ACT_RESET);

	// sticky interrupt status, set beats clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqStatus <= '0;
		end else if (clkEn) begin
			if (wrIrqClr) begin
				irqStatus <= (irqStatus & ~busWdata[IRQ_W-1:0]) | irqEvents;
			end else begin
				irqStatus <= irqStatus | irqEvents;
			end
		end
	end

	// interrupt enable register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqEnable <= IRQ_EN_RESET_VAL;
		end else if (wrIrqEn) begin
			irqEnable <= busWdata[IRQ_W-1:0];
		end
	end

	// level interrupt while any enabled bit stands
	assign irq = |(irqStatus & irqEnable);

	// read mux; reserved and write-only bits read zero
	always_comb begin
		next_rdata = '0;
		if (busRd) begin
			case (busAddr)
				CTL_ADDR: begin
					next_rdata[CTL_RUN_LSB +: CTL_RUN_W] = runCode;
				end
				ST_ADDR: begin
					next_rdata[ST_MODE_BIT] = mode;
					next_rdata[ST_FLAG_BIT] = ovfFlag;
				end
				IRQ_ST_ADDR: begin
					next_rdata[IRQ_W-1:0] = irqStatus;
				end
				IRQ_EN_ADDR: begin
					next_rdata[IRQ_W-1:0] = irqEnable;
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busRdata <= '0;
		end else if (clkEn) begin
			busRdata <= next_rdata;
		end
	end

	// ---- checks on the block's own outputs and state ----
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// a qualified tick while running, not at the top, with no clear
	sequence s_plain_step;
		clkEn && step && !clrWr && cnt != CNT_MAX;
	endsequence

	// the last tick of a period in a given mode
	sequence s_wrap_nmi;
		clkEn && ovfEv && mode == WDG_ACT_NMI;
	endsequence

	sequence s_wrap_reset;
		clkEn && ovfEv && mode == WDG_ACT_RESET;
	endsequence

	tick_advance_a: assert property (
		s_plain_step |=> cnt == $past(cnt) + CNT_ONE
	) else $error("counter did not advance on a tick");

	no_osc_hold_a: assert property (
		clkEn && !oscSync && !clrWr |=> cnt == $past(cnt)
	) else $error("counter moved without the oscillator");

	overflow_wrap_a: assert property (
		clkEn && ovfEv && !clrWr |=> cnt == '0 && ovfFlag
	) else $error("overflow did not wrap and flag");

	nmi_request_a: assert property (
		s_wrap_nmi |=> nmiReq || !clkEn
	) else $error("overflow in nmi mode gave no nmi");

	sleep_hold_a: assert property (
		clkEn && sleepSync && !clrWr |=> $stable(cnt)
	) else $error("counter moved during sleep");

	ctl_read_a: assert property (
		clkEn && busRd && busAddr == CTL_ADDR
			|=> busRdata == {4'h0, $past(runCode)}
	) else $error("control read returned wrong value");

	st_reserved_a: assert property (
		clkEn && busRd && busAddr == ST_ADDR |=> busRdata[7:2] == 6'h00
	) else $error("status reserved bits not zero");

	clear_zero_a: assert property (
		clrWr |=> cnt == '0
	) else $error("clear did not zero counter");

	stop_hold_a: assert property (
		clkEn && !running && !clrWr
			|=> $stable(cnt) ##0 !nmiReq && !resetReq
	) else $error("stopped timer moved or requested");

	reset_mode_a: assert property (
		s_wrap_reset |=> !nmiReq && (resetReq || !clkEn) && ovfFlag
	) else $error("reset mode gave wrong request");

	flag_clear_a: assert property (
		clrWr && !ovfEv |=> !ovfFlag
	) else $error("clear left the overflow flag set");

	run_stop_a: assert property (
		wrCtl |=> running == ($past(busWdata[3:0]) != RUN_STOP_CODE)
	) else $error("run code decode wrong");

	pulse_single_a: assert property (
		nmiReq || resetReq |=> !nmiReq && !resetReq
	) else $error("request pulse longer than one cycle");

	rdata_idle_a: assert property (
		clkEn && !busRd |=> busRdata == '0
	) else $error("read data stood without a read");

	flag_hold_a: assert property (
		clkEn && !ovfEv && !clrWr |=> $stable(ovfFlag)
	) else $error("overflow flag changed without cause");

	reset_flag_a: assert property (
		s_wrap_reset |=> ovfFlag
	) else $error("overflow in reset mode left the flag clear");

	nmi_quiet_a: assert property (
		s_wrap_nmi |=> !resetReq
	) else $error("overflow in nmi mode raised reset");

	idle_quiet_a: assert property (
		clkEn && !ovfEv |=> !nmiReq && !resetReq
	) else $error("request raised without an overflow");

	// a low clock enable freezes the counter, run code, overflow flag and interrupt status
	freeze_hold_a: assert property (
		!clkEn |=> $stable(cnt) && $stable(runCode) && $stable(ovfFlag) && $stable(irqStatus)
	) else $error("state moved with the clock enable low");
endmodule : wdg_supervision_timer

//--- rtl/wdg_pkg.sv
package wdg_pkg;
	// register bus shape
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;

	// register byte addresses
	localparam logic [15:0] CTL_ADDR = 16'h5040;
	localparam logic [15:0] ST_ADDR = 16'h5041;
	localparam logic [15:0] IRQ_ST_ADDR = 16'h5042;
	localparam logic [15:0] IRQ_CLR_ADDR = 16'h5043;
	localparam logic [15:0] IRQ_EN_ADDR = 16'h5044;

	// control register fields
	localparam int unsigned CTL_RUN_LSB = 0;
	localparam int unsigned CTL_RUN_W = 4;
	localparam int unsigned CTL_CLR_BIT = 4;

	// status register fields
	localparam int unsigned ST_FLAG_BIT = 0;
	localparam int unsigned ST_MODE_BIT = 1;

	// interrupt status, clear and enable fields
	localparam int unsigned IRQ_W = 2;
	localparam int unsigned IRQ_NMI_BIT = 0;
	localparam int unsigned IRQ_RST_BIT = 1;

	// reset values
	localparam logic [3:0] RUN_STOP_CODE = 4'ha;
	localparam logic [3:0] RUN_RESET_VAL = RUN_STOP_CODE;
	localparam logic MODE_RESET_VAL = 1'h0;
	localparam logic FLAG_RESET_VAL = 1'h0;
	localparam logic [1:0] IRQ_EN_RESET_VAL = 2'h0;

	// timing: tick rate and overflow period
	localparam int unsigned SLOW_OSC_HZ = 32768;
	localparam int unsigned TICK_HZ = 256;
	localparam int unsigned OVF_OSC_PERIODS = 131072;
	localparam int unsigned OSC_PER_TICK = SLOW_OSC_HZ / TICK_HZ;
	localparam int unsigned OVF_TICKS = OVF_OSC_PERIODS / OSC_PER_TICK;
	localparam int unsigned CNT_W = $clog2(OVF_TICKS);

	// overflow action encoding
	typedef enum logic [0:0] {
		WDG_ACT_NMI = 1'b0,
		WDG_ACT_RESET = 1'b1
	} wdg_action_t;
endpackage : wdg_pkg

//--- rtl/wdg_sync.sv
module wdg_sync #(
	parameter int unsigned WIDTH = 3
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, active high
	input wire logic clkEn, // freezes all state when low
	input wire logic [WIDTH-1:0] asyncIn, // levels from outside the domain
	output logic [WIDTH-1:0] syncOut // two-stage synchronised levels
);
	import wdg_pkg::*;

	logic [WIDTH-1:0] stage1;

	generate
		if (WIDTH < 1) begin : g_bad
			$error("wdg_sync needs at least one bit");
		end
	endgenerate

	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= '0;
		end else if (clkEn) begin
			stage1 <= asyncIn;
		end
	end

	// second stage is the only one the block reads
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncOut <= '0;
		end else if (clkEn) begin
			syncOut <= stage1;
		end
	end
endmodule : wdg_sync

//--- bench/wdg_cpu_model.sv
// cpu side: takes nmi and reset requests, answers a reset request with a system reset
module wdg_cpu_model (
	input wire logic clk, // system clock
	input wire logic nmiReq, // nmi request from the timer
	input wire logic resetReq, // reset request from the timer
	output logic sysRst, // system reset back into the timer
	output int nmiSeen, // nmi pulses taken
	output int rstSeen, // reset pulses taken
	output int longPulse // requests high two cycles running
);
	timeunit 1ns;
	timeprecision 1ps;
	int hold;
	logic nmiPrev;
	logic rstPrev;

	initial begin
		sysRst = 1'b0;
		nmiSeen = 0;
		rstSeen = 0;
		longPulse = 0;
		hold = 0;
		nmiPrev = 1'b0;
		rstPrev = 1'b0;
	end

	// count requests; a reset request pulls the system reset, one cycle later, for a few cycles
	always @(posedge clk) begin
		nmiPrev <= nmiReq;
		rstPrev <= resetReq;
		if (nmiReq === 1'b1) nmiSeen <= nmiSeen + 1;
		if ((nmiReq && nmiPrev) || (resetReq && rstPrev)) longPulse <= longPulse + 1;
		if (resetReq === 1'b1) begin
			rstSeen <= rstSeen + 1;
			hold <= 4;
		end else if (hold > 0) begin
			hold <= hold - 1;
		end
		sysRst <= (hold > 1);
	end
endmodule : wdg_cpu_model

//--- bench/tb_wdg_supervision_timer.sv
module tb_wdg_supervision_timer;
	timeunit 1ns;
	timeprecision 1ps;
	import wdg_pkg::*;
	logic clk, benchRst, clkEn, tickIn, slowOscOn, sleepMode, busWr, busRd;
	logic [15:0] busAddr;
	logic [7:0] busWdata;
	wire logic [7:0] busRdata;
	wire logic nmiReq, resetReq, irq, sysRst;
	wire logic rst = benchRst | sysRst;
	int nmiSeen, rstSeen, longPulse;
	int fail_count = 0;
	int checks_done = 0;
	logic [15:0] rowAddr [6] = '{16'h5040, 16'h5040, 16'h5041, 16'h5041, 16'h5045, 16'h5044};
	logic [7:0] rowWd [6] = '{8'h15, 8'h1a, 8'h03, 8'h01, 8'hff, 8'h03};
	logic [7:0] rowExp [6] = '{8'h05, 8'h0a, 8'h02, 8'h00, 8'h00, 8'h03};

	wdg_supervision_timer #(.CNT_W(2)) wdg_supervision_timer_inst (
		.clk(clk), .rst(rst), .clkEn(clkEn), .tickIn(tickIn), .slowOscOn(slowOscOn),
		.sleepMode(sleepMode), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
		.busRd(busRd), .busRdata(busRdata), .nmiReq(nmiReq), .resetReq(resetReq), .irq(irq)
	);
	wdg_cpu_model wdg_cpu_model_inst (
		.clk(clk), .nmiReq(nmiReq), .resetReq(resetReq), .sysRst(sysRst),
		.nmiSeen(nmiSeen), .rstSeen(rstSeen), .longPulse(longPulse)
	);

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		busWr <= 1'b1;
		busAddr <= a;
		busWdata <= d;
		@(posedge clk);
		busWr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		busRd <= 1'b1;
		busAddr <= a;
		@(posedge clk);
		busRd <= 1'b0;
		#1 chk(busRdata, e);
	endtask : rd

	// whole ticks, four cycles high, five low between ticks and four after the last
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			tickIn <= 1'b1;
			repeat (4) @(posedge clk);
			tickIn <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask : tk

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	// watchdog against a hang
	initial begin
		#(40 * 5000);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		benchRst = 1'b1;
		clkEn = 1'b1;
		tickIn = 1'b0;
		slowOscOn = 1'b1;
		sleepMode = 1'b0;
		busWr = 1'b0;
		busRd = 1'b0;
		busAddr = 16'h0000;
		busWdata = 8'h00;
		repeat (8) @(posedge clk);
		benchRst <= 1'b0;
		repeat (2) @(posedge clk);
		// reset values
		rd(CTL_ADDR, 8'h0a);
		rd(ST_ADDR, 8'h00);
		rd(IRQ_EN_ADDR, 8'h00);
		// ordinary register cases, reserved bits written as zero except the unused address 0x5045, written with ff
		for (int i = 0; i < 6; i++) begin
			wr(rowAddr[i], rowWd[i]);
			rd(rowAddr[i], rowExp[i]);
		end
		wr(ST_ADDR, 8'h00);
		wr(IRQ_EN_ADDR, 8'h01);
		// clear with the run code, overflow after four ticks gives one nmi
		wr(CTL_ADDR, 8'h15);
		tk(3);
		chk(8'(nmiSeen), 8'h00);
		tk(1);
		chk(8'(nmiSeen), 8'h01);
		rd(ST_ADDR, 8'h01);
		chk({7'h00, irq}, 8'h01);
		wr(IRQ_EN_ADDR, 8'h00);
		#1 chk({7'h00, irq}, 8'h00);
		wr(IRQ_EN_ADDR, 8'h01);
		wr(IRQ_CLR_ADDR, 8'h01);
		rd(IRQ_ST_ADDR, 8'h00);
		chk({7'h00, irq}, 8'h00);
		wr(CTL_ADDR, 8'h15);
		rd(ST_ADDR, 8'h00);
		// stop code holds the count, as software does before halt
		tk(2);
		wr(CTL_ADDR, 8'h0a);
		tk(5);
		wr(CTL_ADDR, 8'h05);
		tk(1);
		chk(8'(nmiSeen), 8'h01);
		tk(1);
		chk(8'(nmiSeen), 8'h02);
		// clear in mid period starts afresh
		tk(3);
		wr(CTL_ADDR, 8'h15);
		tk(3);
		chk(8'(nmiSeen), 8'h02);
		// clear before sleep; sleep and a stopped oscillator lose ticks
		wr(CTL_ADDR, 8'h15);
		sleepMode <= 1'b1;
		tk(4);
		sleepMode <= 1'b0;
		slowOscOn <= 1'b0;
		tk(4);
		slowOscOn <= 1'b1;
		chk(8'(nmiSeen), 8'h02);
		tk(3);
		chk(8'(nmiSeen), 8'h02);
		tk(1);
		chk(8'(nmiSeen), 8'h03);
		// reset action: system reset follows and clears the flag
		wr(ST_ADDR, 8'h02);
		wr(CTL_ADDR, 8'h15);
		tk(4);
		repeat (8) @(posedge clk);
		chk(8'(rstSeen), 8'h01);
		chk(8'(nmiSeen), 8'h03);
		rd(ST_ADDR, 8'h00);
		rd(CTL_ADDR, 8'h0a);
		// a write strobe with the clock enable low is ignored
		@(posedge clk);
		clkEn <= 1'b0;
		wr(CTL_ADDR, 8'h05);
		clkEn <= 1'b1;
		rd(CTL_ADDR, 8'h0a);
		chk(8'(longPulse), 8'h00);
		tally_and_finish();
	end
endmodule : tb_wdg_supervision_timer
